// ===== common/mceg_consts.svh
/*
 * constants of the multirate clock enable generator: rate periods, lock timing, mode codes
 * assumes one system clock; included by bare name wherever the values are needed
 */
//
// Summary of operation
// - one enable per rate from sys_clk
// - enable periods are whole sys_clk multiples
// - cycles equal sample period over base period
// - periods 2,3,4 give enables every 2,3,4
// - k base periods equal k sys_clk cycles
// - sys_clk period in ns sets timescale
// - oversampled internal rate also gets an enable
// - three modes: enables, hybrid, exposed clocks
// - manager drives three rates, two if small
// - overflow rates become enables off manager clock
// - priority base, doubled, divided, synthesized; fastest first
// - manager reset input, driven after configuration
// - manager locked output for input alignment
// - exposed mode takes one clock per rate
`ifndef MCEG_CONSTS_SVH
`define MCEG_CONSTS_SVH

// ***************************************************************
// timing
// ***************************************************************
`define MCEG_SYS_CLK_NS      40
`define MCEG_LOCK_TIME_NS    1000
`define MCEG_LOCK_CYCLES     ((`MCEG_LOCK_TIME_NS + `MCEG_SYS_CLK_NS - 1) / `MCEG_SYS_CLK_NS)

// ***************************************************************
// rates in base units
// ***************************************************************
`define MCEG_BASE_PERIOD     1
`define MCEG_PERIOD_A        2
`define MCEG_PERIOD_B        3
`define MCEG_PERIOD_C        4
`define MCEG_OVS_FACTOR      2
`define MCEG_CNT_W           8
`define MCEG_CAP_LARGE       3
`define MCEG_CAP_SMALL       2

// ***************************************************************
// mode select codes
// ***************************************************************
`define MCEG_MODE_ENABLES    2'h0
`define MCEG_MODE_HYBRID     2'h1
`define MCEG_MODE_EXPOSED    2'h2

`endif

// ===== common/mceg_pkg.sv
/*
 * types of the multirate clock enable generator
 * assumes mceg_consts.svh is on the include path
 */
`include "mceg_consts.svh"

package mceg_pkg;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      MCEG_ENABLES = `MCEG_MODE_ENABLES,
      MCEG_HYBRID  = `MCEG_MODE_HYBRID,
      MCEG_EXPOSED = `MCEG_MODE_EXPOSED
   } mceg_mode_type;

   typedef enum {
      MGR_HELD,
      MGR_WAIT,
      MGR_LOCKED
   } mceg_mgr_state_type;

   typedef logic [`MCEG_CNT_W-1:0] mceg_count_type;

   // sample period over the base period gives cycles per enable
   function automatic mceg_count_type mceg_rate_cycles(input int period_units,
                                                      input int base_units);
      int q;
      q = period_units / base_units;
      if (q < 1) begin
         q = 1;
      end
      return mceg_count_type'(q);
   endfunction : mceg_rate_cycles

endpackage : mceg_pkg

// ===== common/mceg_rate_if.sv
/*
 * interface joining one rate counter to the top module
 * assumes both ends run on sys_clk
 */
`timescale 1ns/1ps

interface mceg_rate_if
   import mceg_pkg::*;
   ();
   logic           run;
   mceg_count_type period;
   mceg_count_type count;
   logic           tick;

   modport gen (input run, input period, output count, output tick);
   modport user (output run, output period, input count, input tick);
endinterface : mceg_rate_if

// ===== rtl/mceg_rate_counter.sv
/*
 * wrapping counter that yields one tick per period of sys_clk cycles
 * assumes period is at least one and stays constant while run is high
 */
`timescale 1ns/1ps

module mceg_rate_counter
   import mceg_pkg::*;
(
   // clock and reset
   input  wire logic  sys_clk,
   input  wire logic  nrst,
   // rate link
   mceg_rate_if.gen   rate
);

   // ***************************************************************
   // counter
   // ***************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rate.count <= '0;
      end else if (!rate.run) begin
         rate.count <= '0;
      end else if (rate.count >= rate.period - mceg_count_type'(1)) begin
         rate.count <= '0;
      end else begin
         rate.count <= rate.count + mceg_count_type'(1);
      end
   end

   // ***************************************************************
   // tick, high in the last cycle of each period
   // ***************************************************************
   always_comb begin
      rate.tick = rate.run && (rate.count >= rate.period - mceg_count_type'(1));
   end

endmodule : mceg_rate_counter

// ===== rtl/mceg_top.sv
/*
 * multirate clock enable generator: enable, hybrid manager and exposed clock modes
 * assumes all inputs synchronous to sys_clk; manager outputs are levels built on sys_clk
 */
`timescale 1ns/1ps
`include "mceg_consts.svh"

module mceg_top
   import mceg_pkg::*;
#(
   parameter int PERIOD_A    = `MCEG_PERIOD_A,
   parameter int PERIOD_B    = `MCEG_PERIOD_B,
   parameter int PERIOD_C    = `MCEG_PERIOD_C,
   parameter int BASE_PERIOD = `MCEG_BASE_PERIOD,
   parameter int OVS_FACTOR  = `MCEG_OVS_FACTOR,
   parameter bit SMALL_PART  = 1'b0
)
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // mode and manager control
   input  wire logic [1:0] clk_mode,
   input  wire logic       mgr_reset,
   // externally generated rate clocks
   input  wire logic [2:0] rate_clock_in,
   // per-rate enables
   output logic            rate_enable_2,
   output logic            rate_enable_3,
   output logic            rate_enable_4,
   output logic            oversample_enable,
   // manager clock outputs
   output logic            base_rate_clock_out,
   output logic            doubled_clock_out,
   output logic            divided_clock_out,
   output logic            synthesized_clock_out,
   output logic            mgr_locked
);

   // ***************************************************************
   // rate table
   // ***************************************************************
   localparam int NUM_RATES = 3;
   localparam int NUM_CNT   = NUM_RATES + 1;
   localparam int MGR_CAP   = SMALL_PART ? `MCEG_CAP_SMALL : `MCEG_CAP_LARGE;
   localparam int LOCK_CYC  = `MCEG_LOCK_CYCLES;
   localparam int OVS_UNITS = PERIOD_A / OVS_FACTOR;
   localparam int LOCK_W    = $clog2(LOCK_CYC + 1);

   mceg_count_type cycles [NUM_CNT];
   always_comb begin
      cycles[0] = mceg_rate_cycles(PERIOD_A, BASE_PERIOD);
      cycles[1] = mceg_rate_cycles(PERIOD_B, BASE_PERIOD);
      cycles[2] = mceg_rate_cycles(PERIOD_C, BASE_PERIOD);
      cycles[3] = mceg_rate_cycles(OVS_UNITS, BASE_PERIOD);
   end

   // ***************************************************************
   // mode decode
   // ***************************************************************
   mceg_mode_type mode;
   always_comb begin
      case (clk_mode)
         `MCEG_MODE_HYBRID:  mode = MCEG_HYBRID;
         `MCEG_MODE_EXPOSED: mode = MCEG_EXPOSED;
         default:            mode = MCEG_ENABLES;
      endcase
   end

   // ***************************************************************
   // manager lock sequencer
   // ***************************************************************
   mceg_mgr_state_type mgr_state;
   mceg_mgr_state_type next_mgr_state;
   logic [LOCK_W-1:0]  lock_count;

   always_comb begin
      next_mgr_state = mgr_state;
      case (mgr_state)
         MGR_HELD: begin
            if (mode == MCEG_HYBRID && !mgr_reset) begin
               next_mgr_state = MGR_WAIT;
            end
         end
         MGR_WAIT: begin
            if (lock_count >= LOCK_W'(LOCK_CYC - 1)) begin
               next_mgr_state = MGR_LOCKED;
            end
         end
         MGR_LOCKED: begin
            next_mgr_state = MGR_LOCKED;
         end
         default: begin
            next_mgr_state = MGR_HELD;
         end
      endcase
      if (mgr_reset || mode != MCEG_HYBRID) begin
         next_mgr_state = MGR_HELD;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mgr_state <= MGR_HELD;
      end else begin
         mgr_state <= next_mgr_state;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lock_count <= '0;
      end else if (mgr_state == MGR_WAIT) begin
         lock_count <= lock_count + LOCK_W'(1);
      end else begin
         lock_count <= '0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mgr_locked <= 1'b0;
      end else begin
         mgr_locked <= (next_mgr_state == MGR_LOCKED);
      end
   end

   // ***************************************************************
   // rate counters
   // ***************************************************************
   logic                run_all;
   logic [NUM_CNT-1:0]  tick;
   logic [NUM_CNT-1:0]  level;

   // counters start together; in hybrid mode they wait for lock
   always_comb begin
      case (mode)
         MCEG_ENABLES: run_all = 1'b1;
         MCEG_HYBRID:  run_all = (next_mgr_state == MGR_LOCKED);
         default:      run_all = 1'b0;
      endcase
   end

   mceg_rate_if rif [NUM_CNT] ();

   for (genvar i = 0; i < NUM_CNT; i++) begin : g_rate
      assign rif[i].run    = run_all;
      assign rif[i].period = cycles[i];
      assign tick[i]       = rif[i].tick;
      // first cycles[i] >> 1 cycles of the period high (one of three for period 3), as a clock shape
      assign level[i]      = run_all && (rif[i].count < (cycles[i] >> 1));

      mceg_rate_counter u_cnt (
         .sys_clk (sys_clk),
         .nrst    (nrst),
         .rate    (rif[i])
      );
   end

   // ***************************************************************
   // exposed clock edge detection
   // ***************************************************************
   logic [NUM_RATES-1:0] ext_prev;
   logic [NUM_RATES-1:0] ext_rise;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev <= '0;
      end else begin
         ext_prev <= rate_clock_in;
      end
   end

   assign ext_rise = rate_clock_in & ~ext_prev;

   // ***************************************************************
   // rate to manager slot assignment
   // ***************************************************************
   // rates are listed fastest first, so rate i takes slot i
   logic [NUM_RATES-1:0] on_mgr;
   always_comb begin
      for (int i = 0; i < NUM_RATES; i++) begin
         on_mgr[i] = (mode == MCEG_HYBRID) && (i < MGR_CAP);
      end
   end

   logic [3:0] next_slot;
   always_comb begin
      next_slot = 4'h0;
      for (int i = 0; i < NUM_RATES; i++) begin
         if (on_mgr[i]) begin
            next_slot[i] = level[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         base_rate_clock_out   <= 1'b0;
         doubled_clock_out     <= 1'b0;
         divided_clock_out     <= 1'b0;
         synthesized_clock_out <= 1'b0;
      end else begin
         base_rate_clock_out   <= next_slot[0];
         doubled_clock_out     <= next_slot[1];
         divided_clock_out     <= next_slot[2];
         synthesized_clock_out <= next_slot[3];
      end
   end

   // ***************************************************************
   // per-rate enables
   // ***************************************************************
   logic [NUM_RATES-1:0] next_enable;
   logic                 next_ovs;

   always_comb begin
      for (int i = 0; i < NUM_RATES; i++) begin
         case (mode)
            MCEG_ENABLES: next_enable[i] = tick[i];
            MCEG_HYBRID:  next_enable[i] = tick[i] && !on_mgr[i];
            MCEG_EXPOSED: next_enable[i] = ext_rise[i];
            default:      next_enable[i] = 1'b0;
         endcase
      end
      case (mode)
         MCEG_EXPOSED: next_ovs = 1'b0;
         default:      next_ovs = tick[3];
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rate_enable_2     <= 1'b0;
         rate_enable_3     <= 1'b0;
         rate_enable_4     <= 1'b0;
         oversample_enable <= 1'b0;
      end else begin
         rate_enable_2     <= next_enable[0];
         rate_enable_3     <= next_enable[1];
         rate_enable_4     <= next_enable[2];
         oversample_enable <= next_ovs;
      end
   end

endmodule : mceg_top

// ===== testbench/mceg_top_asserts.sv
/* port checker of mceg_top
   assumes bind to mceg_top, one clock */
`timescale 1ns/1ps
module mceg_top_asserts #(parameter bit SMALL_PART = 1'b0) (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       nrst,
   // inputs
   input wire logic [1:0] clk_mode,
   input wire logic       mgr_reset,
   input wire logic [2:0] rate_clock_in,
   // outputs
   input wire logic       rate_enable_2,
   input wire logic       rate_enable_3,
   input wire logic       rate_enable_4,
   input wire logic       oversample_enable,
   input wire logic       base_rate_clock_out,
   input wire logic       doubled_clock_out,
   input wire logic       divided_clock_out,
   input wire logic       synthesized_clock_out,
   input wire logic       mgr_locked
);
   logic [7:0] age_q;
   logic [1:0] mode_q;
   logic [7:0] wait_cnt;
   logic       hold4;
   wire        m0 = clk_mode == 2'h0;
   // cycles the mode has stayed put, zero in the cycle it changes
   wire  [7:0] age = (clk_mode == mode_q) ? age_q : 8'h00;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) mode_q <= 2'h0;
      else mode_q <= clk_mode;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) age_q <= 8'h00;
      else if (clk_mode != mode_q) age_q <= 8'h00;
      else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
   // cycles released in hybrid
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) wait_cnt <= 8'h00;
      else if (clk_mode == 2'h1 && !mgr_reset) wait_cnt <= wait_cnt + {7'h00, wait_cnt != 8'hFF};
      else wait_cnt <= 8'h00;
   always_ff @(posedge sys_clk) hold4 <= mgr_reset && $past(mgr_reset) && $past(mgr_reset, 2);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   property p_rate2;
      m0 && age > 8'h04 && $past(rate_enable_2, 2) |-> rate_enable_2 && !$past(rate_enable_2);
   endproperty
   a_rate2: assert property (p_rate2) else $error("period 2 enable wrong");
   property p_rate3;
      m0 && age > 8'h04 && $past(rate_enable_3, 3) |-> rate_enable_3
         && !$past(rate_enable_3) && !$past(rate_enable_3, 2);
   endproperty
   a_rate3: assert property (p_rate3) else $error("period 3 enable wrong");
   property p_rate4;
      m0 && age > 8'h05 && $past(rate_enable_4, 4) |-> rate_enable_4 && !$past(rate_enable_4)
         && !$past(rate_enable_4, 2) && !$past(rate_enable_4, 3);
   endproperty
   a_rate4: assert property (p_rate4) else $error("period 4 enable wrong");
   property p_ovs;
      m0 && age > 8'h04 |-> oversample_enable;
   endproperty
   a_ovs: assert property (p_ovs) else $error("oversample enable missing");
   property p_quiet;
      m0 && age > 8'h02 |-> !(mgr_locked | base_rate_clock_out | doubled_clock_out
         | divided_clock_out | synthesized_clock_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("manager active in enable mode");
   property p_hold;
      clk_mode == 2'h1 && age > 8'h03 && hold4 |-> !(mgr_locked | rate_enable_2
         | rate_enable_3 | rate_enable_4 | oversample_enable);
   endproperty
   a_hold: assert property (p_hold) else $error("manager active while held");
   property p_lock;
      $rose(mgr_locked) |-> wait_cnt >= 8'h18 && wait_cnt <= 8'h1C;
   endproperty
   a_lock: assert property (p_lock) else $error("lock time wrong");
   property p_gate;
      clk_mode == 2'h1 && $past(clk_mode) == 2'h1 && !mgr_locked && !$past(mgr_locked)
         |-> !oversample_enable;
   endproperty
   a_gate: assert property (p_gate) else $error("enable before lock");
   property p_hyb;
      clk_mode == 2'h1 && age > 8'h02 && !SMALL_PART |-> !(rate_enable_2 | rate_enable_3 | rate_enable_4);
   endproperty
   a_hyb: assert property (p_hyb) else $error("managed rate has enable");
   property p_base;
      mgr_locked && $past(mgr_locked, 3) |-> base_rate_clock_out != $past(base_rate_clock_out);
   endproperty
   a_base: assert property (p_base) else $error("base clock not period 2");
   property p_div;
      mgr_locked && $past(mgr_locked, 5) |-> doubled_clock_out == $past(doubled_clock_out, 3)
         && divided_clock_out == $past(divided_clock_out, 4) && !synthesized_clock_out;
   endproperty
   a_div: assert property (p_div) else $error("manager clock shape wrong");
   property p_exp;
      clk_mode == 2'h2 && age > 8'h03 |-> {rate_enable_4, rate_enable_3, rate_enable_2} ==
         ($past(rate_clock_in) & ~$past(rate_clock_in, 2)) && !oversample_enable && !mgr_locked;
   endproperty
   a_exp: assert property (p_exp) else $error("exposed clock enable wrong");
   c_e4: cover property (m0 && rate_enable_4);
   c_lock: cover property ($rose(mgr_locked));
   c_exp: cover property (clk_mode == 2'h2 && rate_enable_3);
endmodule : mceg_top_asserts
bind mceg_top mceg_top_asserts #(.SMALL_PART(SMALL_PART)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
   .clk_mode(clk_mode), .mgr_reset(mgr_reset), .rate_clock_in(rate_clock_in),
   .rate_enable_2(rate_enable_2), .rate_enable_3(rate_enable_3), .rate_enable_4(rate_enable_4),
   .oversample_enable(oversample_enable), .base_rate_clock_out(base_rate_clock_out),
   .doubled_clock_out(doubled_clock_out), .divided_clock_out(divided_clock_out),
   .synthesized_clock_out(synthesized_clock_out), .mgr_locked(mgr_locked));

// ===== testbench/mceg_far_end.sv
/* surrounding logic and external clock generator
   assumes requests from the bench, updates on sys_clk */
`timescale 1ns/1ps
module mceg_far_end (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // bench requests
   input  wire logic       hold_req,
   input  wire logic [2:0] run_mask,
   // toward the block
   output logic            mgr_reset,
   output logic [2:0]      rate_clock_in
);
   logic [3:0] cnt;
   // manager kept in reset after configuration until released
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) mgr_reset <= 1'b1;
      else mgr_reset <= hold_req;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) cnt <= 4'h0;
      else cnt <= (cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
   // one clock per rate; a stopped clock stands low
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) rate_clock_in <= 3'h0;
      else rate_clock_in <= run_mask & {cnt < 4'h6, cnt % 6 < 3, cnt[0]};
endmodule : mceg_far_end

// ===== testbench/tb_top.sv
/* self-checking bench of mceg_top
   assumes default parameters */
`timescale 1ns/1ps
module tb_top;
   logic sys_clk, nrst, hold_req, mgr_reset, e2, e3, e4, ovs, base, dbl, div, syn, lock, p;
   logic [1:0]  clk_mode;
   logic [2:0]  run_mask, rci, a, b;
   logic [31:0] lf;
   int          fails, samples_checked, cyc, n, hd, hv;
   mceg_top dut (.sys_clk(sys_clk), .nrst(nrst), .clk_mode(clk_mode), .mgr_reset(mgr_reset),
      .rate_clock_in(rci), .rate_enable_2(e2), .rate_enable_3(e3), .rate_enable_4(e4),
      .oversample_enable(ovs), .base_rate_clock_out(base), .doubled_clock_out(dbl),
      .divided_clock_out(div), .synthesized_clock_out(syn), .mgr_locked(lock));
   mceg_far_end far (.sys_clk(sys_clk), .nrst(nrst), .hold_req(hold_req), .run_mask(run_mask),
      .mgr_reset(mgr_reset), .rate_clock_in(rci));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_sim();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   function automatic logic exp_en(input int c, input int k);
      return c > 0 && c % k == 0;
   endfunction : exp_en
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic cyc_n(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : cyc_n
   task automatic walk;
      nrst = 1'b0;
      cyc_n(6);
      nrst = 1'b1;
      for (int c = 1; c <= 24; c++) begin
         cyc_n(1);
         chk(8'({e4, e3, e2}), 8'({exp_en(c, 4), exp_en(c, 3), exp_en(c, 2)}));
         chk(8'(ovs), 8'h01);
         chk(8'({lock, base, dbl, div, syn}), 8'h00);
      end
   endtask : walk
   initial begin
      {nrst, hold_req, clk_mode, run_mask, lf} = {2'b01, 5'h00, 32'hB8BB};
      {fails, samples_checked, cyc} = 0;
      @(negedge sys_clk);
      walk();
      // code 3 falls back to enables
      clk_mode = 2'h3;
      cyc_n(6);
      p = e2;
      repeat (8) begin
         cyc_n(1);
         chk(8'(e2), 8'(!p));
         p = e2;
      end
      clk_mode = 2'h1;
      lf = lfsr(lf);
      cyc_n(6 + lf[3:0]);
      chk(8'({lock, e2, e3, e4, ovs}), 8'h00);
      hold_req = 1'b0;
      n = 0;
      while (!lock && n < 60) begin
         cyc_n(1);
         n++;
      end
      chk(8'(n >= 24 && n <= 30), 8'h01);
      {p, hd, hv} = {base, 64'h0};
      for (int i = 0; i < 12; i++) begin
         cyc_n(1);
         chk(8'({base ^ p, syn, e2 | e3 | e4}), 8'h04);
         {p, hd, hv} = {base, hd + dbl, hv + div};
      end
      chk(8'(hd), 8'h04);
      chk(8'(hv), 8'h06);
      hold_req = 1'b1;
      cyc_n(3);
      chk(8'(lock), 8'h00);
      clk_mode = 2'h2;
      for (int r = 0; r < 4; r++) begin
         lf = lfsr(lf);
         run_mask = (r == 0) ? 3'h7 : lf[2:0];
         cyc_n(3);
         a = rci;
         cyc_n(1);
         b = rci;
         repeat (16) begin
            cyc_n(1);
            chk(8'({e4, e3, e2}), 8'(b & ~a));
            chk(8'({ovs, base, lock}), 8'h00);
            {a, b} = {b, rci};
         end
      end
      // second reset in mid run
      clk_mode = 2'h0;
      walk();
      repeat (8) begin
         lf = lfsr(lf);
         {hold_req, run_mask, clk_mode} = lf[5:0];
         cyc_n(12);
      end
      end_sim();
   end
endmodule : tb_top
